// ==== design/pup_params.svh ====
// Constants of the pixel unpack and transfer pipe: offsets, fields, resets.
// Assumes byte addresses on a 32-bit classic Wishbone register port.
`ifndef PUP_PARAMS_SVH
`define PUP_PARAMS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define PUP_ADR_W        12
`define PUP_REG_CTRL     12'h000
`define PUP_REG_SHIFT    12'h004
`define PUP_REG_OFFSET   12'h008
`define PUP_REG_STATUS   12'h00c
`define PUP_REG_SIZES    12'h010
`define PUP_GAIN_PAGE    7'h01
`define PUP_BIAS_PAGE    7'h02
`define PUP_TBL_PAGE     2'h1
`define PUP_NUM_CH       5
`define PUP_NUM_TBL      9
`define PUP_TBL_DEPTH    16

// ****************************************************************
// Control fields and table numbers
// ****************************************************************
`define PUP_CTRL_SWAP    0
`define PUP_CTRL_MAP     1
`define PUP_CTRL_EXPAND  2
`define PUP_CH_DEPTH     4
`define PUP_TBL_PAL_RGBA 4
`define PUP_TBL_PAL_PAL  8

// ****************************************************************
// Reset values and fixed-point figures
// ****************************************************************
`define PUP_ONE_Q16      32'h0001_0000
`define PUP_HALF_Q16     32'h0000_8000
`define PUP_SAT_Q16      32'h7fff_ffff
`define PUP_GAIN_RST     32'h0001_0000
`define PUP_BIAS_RST     32'h0000_0000
`define PUP_SE_BIAS      15
`define PUP_SE_MANT      9

`endif

// ==== design/pup_pkg.sv ====
// Types of the pixel unpack and transfer pipe.
// Assumes nothing beyond the constants header.
`default_nettype none

package pup_pkg;
  typedef enum logic [3:0] {
    PUP_FMT_RGB, PUP_FMT_RGBA, PUP_FMT_REV, PUP_FMT_DS, PUP_FMT_GREY,
    PUP_FMT_GREY_OP, PUP_FMT_PALETTE, PUP_FMT_STENCIL, PUP_FMT_DEPTH
  } pup_fmt_t;
  typedef enum logic [2:0] {
    PUP_TY_U8X4, PUP_TY_S8X4, PUP_TY_SMALL_FLOAT, PUP_TY_SHARED_EXP,
    PUP_TY_U24_8, PUP_TY_U32
  } pup_type_t;
  typedef enum logic [2:0] {
    PUP_K_FRGBA, PUP_K_IRGBA, PUP_K_DEPTH, PUP_K_INDEX, PUP_K_STENCIL, PUP_K_DS
  } pup_kind_t;
endpackage : pup_pkg

`default_nettype wire

// ==== design/pup_transfer_pipe.sv ====
// Pixel unpack and transfer pipe: one packed word in, one group out.
// Assumes a classic Wishbone master and a valid/ready pixel source and sink.
//
// Notes on behaviour
// RULE_01 - Fields map to components by format
// RULE_02 - Byte swap happens before field extraction
// RULE_03 - Each packed word is one whole group
// RULE_04 - Small-float word splits 11, 11, 10 bits
// RULE_05 - Small-float fields decode as unsigned floats
// RULE_06 - Shared exponent: mantissa times 2^(e-15-9)
// RULE_07 - Only float groups convert; indices pass raw
// RULE_08 - Unsigned and signed elements normalise differently
// RULE_09 - Grey level copies into red, green, blue
// RULE_10 - Grey with opacity: copies plus alpha
// RULE_11 - Missing alpha is one, missing colour zero
// RULE_12 - Integer RGBA groups pass transfer untouched
// RULE_13 - Stages run in order, skipping inapplicable
// RULE_14 - Colour and depth get gain then offset
// RULE_15 - Indices become fixed point, integer fraction zero
// RULE_16 - Index shifted by signed count, offset added
// RULE_17 - Colour map: clamp, scale, round, replace
// RULE_18 - Palette expands when RGBA output required
// RULE_19 - Expansion: rounded masked index, four tables
// RULE_20 - Else mapped through palette-to-palette table
// RULE_21 - Palette tables sized by powers of two
// RULE_22 - Ordered stages, one group per handshake
// RULE_23 - Configuration changes only between images
//
// Our own choices: the Wishbone slave port and the register addresses.
`include "pup_params.svh"
`timescale 1ns/1ns
`default_nettype none

module pup_transfer_pipe (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [`PUP_ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  input  wire logic                    pix_valid_i,
  output logic                         pix_ready_o,
  input  wire logic [31:0]             pix_word_i,
  input  wire pup_pkg::pup_fmt_t       pix_fmt_i,
  input  wire pup_pkg::pup_type_t      pix_type_i,
  input  wire logic                    pix_int_i,
  output logic                         grp_valid_o,
  input  wire logic                    grp_ready_i,
  output pup_pkg::pup_kind_t           grp_kind_o,
  output logic      [31:0]             grp_c0_o,
  output logic      [31:0]             grp_c1_o,
  output logic      [31:0]             grp_c2_o,
  output logic      [31:0]             grp_c3_o
);
  import pup_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [2:0]                                ctrl;
    logic [4:0]                                shift;
    logic [31:0]                               offset;
    logic [`PUP_NUM_CH-1:0][31:0]              gain;
    logic [`PUP_NUM_CH-1:0][31:0]              bias;
    logic [`PUP_NUM_TBL-1:0][2:0]              lg;
    logic [`PUP_NUM_TBL-1:0][`PUP_TBL_DEPTH-1:0][15:0] tbl;
    logic                                      ov;
    pup_kind_t                                 okind;
    logic [3:0][31:0]                          od;
    logic                                      ack;
    logic [31:0]                               rdat;
    logic [15:0]                               cnt;
  } pup_state_t;

  pup_state_t q;
  pup_state_t d;

  // ****************************************************************
  // Arithmetic helpers
  // ****************************************************************
  function automatic logic [31:0] pup_mul(input logic [31:0] a, input logic [31:0] b);
    logic signed [63:0] p;
    p = $signed(a) * $signed(b);
    return p[47:16];
  endfunction : pup_mul

  function automatic logic [31:0] pup_sat(input logic [63:0] v);
    return (v > 64'h0000_0000_7fff_ffff) ? `PUP_SAT_Q16 : v[31:0];
  endfunction : pup_sat

  // Unsigned small float, 5-bit exponent, 6-bit mantissa, to Q16.16
  function automatic logic [31:0] pup_sf(input logic [4:0] e, input logic [5:0] m);
    logic [63:0] v;
    v = 64'h0;
    if (e == 5'h1f) v = 64'hffff_ffff;
    else if (e == 5'h00) v = {62'h0, m[5:4]};
    else v = ({57'h0, 1'b1, m} << e) >> 5;
    return pup_sat(v);
  endfunction : pup_sf

  // Shared-exponent element to Q16.16; 16 fraction bits less bias and width
  function automatic logic [31:0] pup_se(input logic [8:0] m, input logic [4:0] e);
    logic [63:0] v;
    v = ({55'h0, m} << e) >> (`PUP_SE_BIAS + `PUP_SE_MANT - 16);
    return pup_sat(v);
  endfunction : pup_se

  function automatic logic [31:0] pup_merge(input logic [31:0] o, input logic [31:0] n,
                                            input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) if (s[i]) r[8*i +: 8] = n[8*i +: 8];
    return r;
  endfunction : pup_merge

  // Round Q16.16 index, mask by a power-of-two table size
  function automatic logic [3:0] pup_addr(input logic [31:0] x, input logic [2:0] lg);
    logic [31:0] r;
    logic [3:0]  m;
    r = x + `PUP_HALF_Q16;
    m = 4'((5'h01 << lg) - 5'h01);
    return r[19:16] & m;
  endfunction : pup_addr

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic hit;
  logic idle;
  logic take;

  always_comb begin
    logic [31:0]      w;
    logic [31:0]      r;
    logic [31:0]      mrg;
    logic [3:0][31:0] f;
    logic [3:0][31:0] e;
    logic [31:0]      one;
    logic [31:0]      x;
    logic [31:0]      cl;
    logic [35:0]      pr;
    logic             conv;
    logic             idx;
    pup_kind_t        k;
    w    = pix_word_i;
    r    = 32'h0;
    mrg  = 32'h0;
    f    = '0;
    e    = '0;
    x    = 32'h0;
    cl   = 32'h0;
    pr   = 36'h0;
    k    = PUP_K_FRGBA;
    idx  = (pix_fmt_i == PUP_FMT_PALETTE) | (pix_fmt_i == PUP_FMT_STENCIL);
    conv = ~pix_int_i & ~idx; // [RULE_07]
    one  = 32'h0;
    d    = q;
    d.ack = 1'b0;

    // Wishbone slave; writes wait for an idle pipe so a stream sees one setup
    idle = ~q.ov & ~pix_valid_i;
    hit  = wb_cyc_i & wb_stb_i & ~q.ack;
    if (hit & (~wb_we_i | idle)) begin // [RULE_23]
      d.ack = 1'b1;
      if (wb_adr_i == `PUP_REG_CTRL) r = {29'h0, q.ctrl};
      else if (wb_adr_i == `PUP_REG_SHIFT) r = {27'h0, q.shift};
      else if (wb_adr_i == `PUP_REG_OFFSET) r = q.offset;
      else if (wb_adr_i == `PUP_REG_STATUS) r = {q.cnt, 15'h0, q.ov};
      else if (wb_adr_i == `PUP_REG_SIZES) r = {5'h0, q.lg};
      else if (wb_adr_i[11:5] == `PUP_GAIN_PAGE && wb_adr_i[4:2] < `PUP_NUM_CH)
        r = q.gain[wb_adr_i[4:2]];
      else if (wb_adr_i[11:5] == `PUP_BIAS_PAGE && wb_adr_i[4:2] < `PUP_NUM_CH)
        r = q.bias[wb_adr_i[4:2]];
      else if (wb_adr_i[11:10] == `PUP_TBL_PAGE && wb_adr_i[9:6] < `PUP_NUM_TBL)
        r = {16'h0, q.tbl[wb_adr_i[9:6]][wb_adr_i[5:2]]};
      mrg = pup_merge(r, wb_dat_i, wb_sel_i);
      d.rdat = wb_we_i ? 32'h0 : r;
      if (wb_we_i) begin
        if (wb_adr_i == `PUP_REG_CTRL) d.ctrl = mrg[2:0];
        else if (wb_adr_i == `PUP_REG_SHIFT) d.shift = mrg[4:0];
        else if (wb_adr_i == `PUP_REG_OFFSET) d.offset = mrg;
        else if (wb_adr_i == `PUP_REG_SIZES) d.lg = mrg[26:0]; // [RULE_21]
        else if (wb_adr_i[11:5] == `PUP_GAIN_PAGE && wb_adr_i[4:2] < `PUP_NUM_CH)
          d.gain[wb_adr_i[4:2]] = mrg;
        else if (wb_adr_i[11:5] == `PUP_BIAS_PAGE && wb_adr_i[4:2] < `PUP_NUM_CH)
          d.bias[wb_adr_i[4:2]] = mrg;
        else if (wb_adr_i[11:10] == `PUP_TBL_PAGE && wb_adr_i[9:6] < `PUP_NUM_TBL)
          d.tbl[wb_adr_i[9:6]][wb_adr_i[5:2]] = mrg[15:0];
      end
    end

    // Stage 1: whole word is one group, swapped before any field is cut
    if (q.ctrl[`PUP_CTRL_SWAP]) w = {w[7:0], w[15:8], w[23:16], w[31:24]}; // [RULE_02] [RULE_03]
    case (pix_type_i)
      PUP_TY_U8X4: begin
        for (int i = 0; i < 4; i++) begin
          f[i] = {24'h0, w[31-8*i -: 8]};
          if (conv) f[i] = f[i] * 32'd257 + (f[i] >> 7); // [RULE_08]
        end
      end
      PUP_TY_S8X4: begin
        for (int i = 0; i < 4; i++) begin
          f[i] = {{24{w[31-8*i]}}, w[31-8*i -: 8]};
          if (conv && w[31-8*i -: 8] == 8'h80) f[i] = 32'hffff_ff81;
          if (conv) f[i] = f[i] * 32'd516 + 32'($signed(f[i]) >>> 5); // [RULE_08]
        end
      end
      PUP_TY_SMALL_FLOAT: begin // [RULE_04] [RULE_05]
        conv = 1'b1;
        f[0] = pup_sf(w[10:6], w[5:0]);
        f[1] = pup_sf(w[21:17], w[16:11]);
        f[2] = pup_sf(w[31:27], {w[26:22], 1'b0});
      end
      PUP_TY_SHARED_EXP: begin // [RULE_06]
        conv = 1'b1;
        for (int i = 0; i < 3; i++) f[i] = pup_se(w[9*i +: 9], w[31:27]);
      end
      PUP_TY_U24_8: begin
        f[0] = {8'h0, w[31:8]};
        if (conv) f[0] = (f[0] >> 8) + (f[0] >> 23);
        f[1] = {24'h0, w[7:0]}; // [RULE_07]
      end
      default: begin
        f[0] = conv ? (w >> 16) + (w >> 31) : w;
      end
    endcase

    // Field assignment, grey expansion, completion to four elements
    one = conv ? `PUP_ONE_Q16 : 32'h1; // [RULE_11]
    k   = pix_int_i ? PUP_K_IRGBA : PUP_K_FRGBA;
    case (pix_fmt_i) // [RULE_01]
      PUP_FMT_RGB:     e = {one, f[2], f[1], f[0]}; // [RULE_11]
      PUP_FMT_RGBA:    e = f;
      PUP_FMT_REV:     e = {f[3], f[0], f[1], f[2]};
      PUP_FMT_GREY:    e = {one, f[0], f[0], f[0]}; // [RULE_09]
      PUP_FMT_GREY_OP: e = {f[1], f[0], f[0], f[0]}; // [RULE_10]
      PUP_FMT_DS: begin
        e = {64'h0, f[1], f[0]};
        k = PUP_K_DS;
      end
      PUP_FMT_DEPTH: begin
        e = {96'h0, f[0]};
        k = PUP_K_DEPTH;
      end
      PUP_FMT_PALETTE: begin
        e = {96'h0, f[0]};
        k = PUP_K_INDEX;
      end
      PUP_FMT_STENCIL: begin
        e = {96'h0, f[0]};
        k = PUP_K_STENCIL;
      end
      default: e = f;
    endcase

    // Transfer stages in order; integer RGBA falls through every case
    case (k) // [RULE_13] [RULE_12]
      PUP_K_FRGBA: begin
        for (int i = 0; i < 4; i++) begin
          e[i] = pup_mul(e[i], q.gain[i]) + q.bias[i]; // [RULE_14]
          if (q.ctrl[`PUP_CTRL_MAP]) begin // [RULE_17]
            cl = e[i][31] ? 32'h0 : (e[i] > `PUP_ONE_Q16 ? `PUP_ONE_Q16 : e[i]);
            pr = 36'(cl * {28'h0, 4'((5'h01 << q.lg[i]) - 5'h01)}) + 36'(`PUP_HALF_Q16);
            e[i] = {16'h0, q.tbl[i][pr[19:16]]};
          end
        end
      end
      PUP_K_DEPTH, PUP_K_DS: begin
        e[0] = pup_mul(e[0], q.gain[`PUP_CH_DEPTH]) + q.bias[`PUP_CH_DEPTH]; // [RULE_14]
      end
      default: ;
    endcase
    if (k == PUP_K_INDEX || k == PUP_K_STENCIL || k == PUP_K_DS) begin
      x = {e[k == PUP_K_DS][15:0], 16'h0}; // [RULE_15]
      if (!q.shift[4] && q.shift != 5'h00) x = x << q.shift; // [RULE_16]
      else x = x >> 5'(-q.shift);
      x = x + {q.offset[15:0], 16'h0}; // [RULE_16]
      e[k == PUP_K_DS] = x;
    end
    if (k == PUP_K_INDEX) begin
      if (q.ctrl[`PUP_CTRL_EXPAND]) begin // [RULE_18]
        for (int i = 0; i < 4; i++) // [RULE_19]
          e[i] = {16'h0, q.tbl[`PUP_TBL_PAL_RGBA+i][pup_addr(x, q.lg[`PUP_TBL_PAL_RGBA+i])]};
        k = PUP_K_FRGBA;
      end else if (q.ctrl[`PUP_CTRL_MAP]) begin // [RULE_20]
        e[0] = {q.tbl[`PUP_TBL_PAL_PAL][pup_addr(x, q.lg[`PUP_TBL_PAL_PAL])], 16'h0};
      end
    end

    // Output register, one group per handshake
    take = pix_valid_i & pix_ready_o; // [RULE_22]
    if (take) begin
      d.ov    = 1'b1;
      d.okind = k;
      d.od    = e;
      d.cnt   = q.cnt + 16'h1;
    end else if (grp_ready_i) begin
      d.ov = 1'b0;
    end

    if (rst_i) begin
      d       = '0;
      d.gain  = {`PUP_NUM_CH{`PUP_GAIN_RST}};
      d.bias  = {`PUP_NUM_CH{`PUP_BIAS_RST}};
      d.okind = PUP_K_FRGBA;
    end
  end

  always_ff @(posedge clk_i) begin
    q <= d;
  end

  // ****************************************************************
  // Ports
  // ****************************************************************
  assign pix_ready_o = ~q.ov | grp_ready_i; // [RULE_22]
  assign wb_ack_o    = q.ack;
  assign wb_dat_o    = q.rdat;
  assign grp_valid_o = q.ov;
  assign grp_kind_o  = q.okind;
  assign grp_c0_o    = q.od[0];
  assign grp_c1_o    = q.od[1];
  assign grp_c2_o    = q.od[2];
  assign grp_c3_o    = q.od[3];

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_take;
    pix_valid_i && pix_ready_o;
  endsequence

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("Ack held two cycles"); // [RULE_23]

  property p_wr_busy;
    (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && (grp_valid_o || pix_valid_i))
      |=> !wb_ack_o;
  endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("Write taken mid-stream"); // [RULE_23]

  property p_take;
    s_take |=> grp_valid_o;
  endproperty
  a_take: assert property (p_take) else $error("Group lost"); // [RULE_22]

  property p_stall;
    grp_valid_o && !grp_ready_i |=> grp_valid_o && $stable(grp_c0_o) && pix_ready_o == grp_ready_i;
  endproperty
  a_stall: assert property (p_stall) else $error("Group changed under stall"); // [RULE_22]

  property p_int_rgba;
    s_take ##0 (pix_int_i && pix_fmt_i == PUP_FMT_RGBA && pix_type_i == PUP_TY_U8X4
                && !q.ctrl[`PUP_CTRL_SWAP])
      |=> grp_kind_o == PUP_K_IRGBA && grp_c0_o == {24'h0, $past(pix_word_i[31:24])}
          && grp_c3_o == {24'h0, $past(pix_word_i[7:0])};
  endproperty
  a_int_rgba: assert property (p_int_rgba) else $error("Integer RGBA altered"); // [RULE_12]

  property p_swap;
    s_take ##0 (pix_int_i && pix_fmt_i == PUP_FMT_RGBA && pix_type_i == PUP_TY_U8X4
                && q.ctrl[`PUP_CTRL_SWAP])
      |=> grp_c0_o == {24'h0, $past(pix_word_i[7:0])};
  endproperty
  a_swap: assert property (p_swap) else $error("Swap not before extraction"); // [RULE_02]

  property p_grey;
    s_take ##0 (pix_fmt_i == PUP_FMT_GREY && pix_int_i)
      |=> grp_c0_o == grp_c1_o && grp_c1_o == grp_c2_o && grp_c3_o == 32'h1;
  endproperty
  a_grey: assert property (p_grey) else $error("Grey expansion wrong"); // [RULE_09]

  property p_int_alpha;
    s_take ##0 (pix_fmt_i == PUP_FMT_RGB && pix_int_i && pix_type_i == PUP_TY_U8X4)
      |=> grp_c3_o == 32'h1;
  endproperty
  a_int_alpha: assert property (p_int_alpha) else $error("Alpha not one"); // [RULE_11]

  property p_stencil;
    s_take ##0 (pix_fmt_i == PUP_FMT_DS && pix_type_i == PUP_TY_U24_8 && q.shift == 5'h00
                && q.offset == 32'h0 && !q.ctrl[`PUP_CTRL_SWAP])
      |=> grp_kind_o == PUP_K_DS && grp_c1_o == {8'h0, $past(pix_word_i[7:0]), 16'h0};
  endproperty
  a_stencil: assert property (p_stencil) else $error("Stencil index converted"); // [RULE_07]

  property p_expand;
    s_take ##0 (pix_fmt_i == PUP_FMT_PALETTE && q.ctrl[`PUP_CTRL_EXPAND])
      |=> grp_kind_o == PUP_K_FRGBA && grp_c0_o[31:16] == 16'h0;
  endproperty
  a_expand: assert property (p_expand) else $error("Palette not expanded"); // [RULE_18]
endmodule : pup_transfer_pipe

`default_nettype wire

// ==== verification/pixel_unpack_transfer_pipe_tb_top.sv ====
// Self-checking bench of the pixel unpack and transfer pipe.
// Assumes the pipe header, package and the consumer model.
`include "pup_params.svh"
`timescale 1ns/1ns
`default_nettype none

module pixel_unpack_transfer_pipe_tb_top;
  import pup_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0]  sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic        pvalid = 1'b0;
  logic [31:0] word = 32'h0;
  pup_fmt_t    fmt = PUP_FMT_RGBA;
  pup_type_t   ty = PUP_TY_U8X4;
  logic        pint = 1'b0;
  logic [3:0]  stall = 4'h0;
  logic [31:0] wb_dat_o, c0, c1, c2, c3;
  logic        wb_ack_o, pix_ready_o, grp_valid_o, grp_ready;
  pup_kind_t   grp_kind_o, got_kind;
  logic [127:0] got_data;
  logic [7:0]  got_cnt;
  int          errors = 0;
  int          tests_run = 0;

  always #5 clk_i = ~clk_i;

  pup_transfer_pipe pup_transfer_pipe_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pix_valid_i(pvalid), .pix_ready_o(pix_ready_o),
    .pix_word_i(word), .pix_fmt_i(fmt), .pix_type_i(ty), .pix_int_i(pint),
    .grp_valid_o(grp_valid_o), .grp_ready_i(grp_ready), .grp_kind_o(grp_kind_o),
    .grp_c0_o(c0), .grp_c1_o(c1), .grp_c2_o(c2), .grp_c3_o(c3));

  pup_sink_model pup_sink_model_i (
    .clk_i(clk_i), .rst_i(rst_i), .grp_valid_i(grp_valid_o), .grp_kind_i(grp_kind_o),
    .grp_data_i({c3, c2, c1, c0}), .stall_i(stall), .grp_ready_o(grp_ready),
    .got_kind_o(got_kind), .got_data_o(got_data), .got_cnt_o(got_cnt));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic give_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Holds the request until ack is sampled; no answer time assumed
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hf;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    check(128'(r), 128'(exp));
  endtask : rdchk

  task automatic px(input pup_fmt_t f, input pup_type_t t, input logic i,
                    input logic [31:0] w);
    logic [7:0] n;
    n = got_cnt;
    pvalid <= 1'b1;
    fmt <= f;
    ty <= t;
    pint <= i;
    word <= w;
    do @(posedge clk_i); while (pix_ready_o !== 1'b1);
    pvalid <= 1'b0;
    while (got_cnt == n) @(posedge clk_i);
  endtask : px

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic s_regs();
    rdchk(`PUP_REG_CTRL, 32'h0);
    rdchk(12'h020, 32'h0001_0000);
    rdchk(12'h050, 32'h0);
    rdchk(`PUP_REG_STATUS, 32'h0);
    wr(12'h0f0, 32'h1234_5678);
    rdchk(12'h0f0, 32'h0);
    wr(12'h050, 32'h0000_8000);
    rdchk(12'h050, 32'h0000_8000);
  endtask : s_regs

  task automatic s_fields();
    wr(12'h020, 32'h0002_0000);
    px(PUP_FMT_RGBA, PUP_TY_U8X4, 1'b1, 32'h1122_3344);
    check(128'(got_kind), 128'(PUP_K_IRGBA));
    check(got_data, {32'h44, 32'h33, 32'h22, 32'h11});
    px(PUP_FMT_REV, PUP_TY_U8X4, 1'b1, 32'h1122_3344);
    check(got_data, {32'h44, 32'h11, 32'h22, 32'h33});
    wr(`PUP_REG_CTRL, 32'h1);
    px(PUP_FMT_RGBA, PUP_TY_U8X4, 1'b1, 32'h1122_3344);
    check(got_data, {32'h11, 32'h22, 32'h33, 32'h44});
    wr(`PUP_REG_CTRL, 32'h0);
    px(PUP_FMT_GREY, PUP_TY_U8X4, 1'b1, 32'h7700_0000);
    check(got_data, {32'h1, 32'h77, 32'h77, 32'h77});
    px(PUP_FMT_RGB, PUP_TY_U8X4, 1'b1, 32'h1122_3344);
    check(got_data, {32'h1, 32'h33, 32'h22, 32'h11});
  endtask : s_fields

  // Red gain is 2.0 from here on, so every float red shows scaling
  task automatic s_float();
    px(PUP_FMT_GREY, PUP_TY_U8X4, 1'b0, 32'hff00_0000);
    check(got_data, {32'h10000, 32'h10000, 32'h10000, 32'h20000});
    px(PUP_FMT_GREY_OP, PUP_TY_U8X4, 1'b0, 32'h80ff_0000);
    check(got_data, {32'h10000, 32'h8081, 32'h8081, 32'h10102});
    px(PUP_FMT_RGBA, PUP_TY_S8X4, 1'b0, 32'h7f80_0000);
    check(got_data, {32'h0, 32'h0, 32'hffff0000, 32'h1fffe});
    px(PUP_FMT_RGB, PUP_TY_SMALL_FLOAT, 1'b0, 32'h7820_03c0);
    check(got_data, {32'h10000, 32'h10000, 32'h20000, 32'h20000});
    px(PUP_FMT_RGB, PUP_TY_SHARED_EXP, 1'b0, 32'h8005_0100);
    check(got_data, {32'h10000, 32'h100, 32'h8000, 32'h20000});
    wr(12'h030, 32'h0002_0000);
    px(PUP_FMT_DS, PUP_TY_U24_8, 1'b0, 32'hffff_ff05);
    check(128'(got_kind), 128'(PUP_K_DS));
    check(128'(got_data[31:0]), 128'(32'h28000));
    check(128'(got_data[63:32]), 128'(32'h50000));
  endtask : s_float

  task automatic s_index();
    px(PUP_FMT_PALETTE, PUP_TY_U32, 1'b1, 32'h5);
    check(128'(got_kind), 128'(PUP_K_INDEX));
    check(128'(got_data[31:0]), 128'(32'h50000));
    wr(`PUP_REG_SHIFT, 32'h1);
    wr(`PUP_REG_OFFSET, 32'h3);
    px(PUP_FMT_PALETTE, PUP_TY_U32, 1'b1, 32'h5);
    check(128'(got_data[31:0]), 128'(32'hd0000));
    wr(`PUP_REG_SHIFT, 32'h1f);
    px(PUP_FMT_PALETTE, PUP_TY_U32, 1'b1, 32'h7);
    check(128'(got_data[31:0]), 128'(32'h68000));
    wr(`PUP_REG_SHIFT, 32'h0);
    wr(`PUP_REG_OFFSET, 32'h0);
    wr(`PUP_REG_SIZES, 32'h0100_2002);
    wr(12'h504, 32'h1234);
    wr(12'h40c, 32'h4444);
    wr(12'h604, 32'h0007);
    wr(`PUP_REG_CTRL, 32'h4);
    px(PUP_FMT_PALETTE, PUP_TY_U32, 1'b1, 32'hd);
    check(128'(got_kind), 128'(PUP_K_FRGBA));
    check(got_data, {32'h0, 32'h0, 32'h0, 32'h1234});
    wr(`PUP_REG_CTRL, 32'h2);
    px(PUP_FMT_PALETTE, PUP_TY_U32, 1'b1, 32'hd);
    check(128'(got_data[31:0]), 128'(32'h70000));
    px(PUP_FMT_RGBA, PUP_TY_U8X4, 1'b0, 32'hff00_0000);
    check(got_data, {32'h0, 32'h0, 32'h0, 32'h4444});
    wr(`PUP_REG_CTRL, 32'h0);
  endtask : s_index

  // Slow sink: second word must wait and the first group must hold
  task automatic s_stall();
    logic [7:0] n;
    n = got_cnt;
    stall <= 4'h3;
    pvalid <= 1'b1;
    fmt <= PUP_FMT_RGBA;
    pint <= 1'b1;
    word <= 32'h0102_0304;
    @(posedge clk_i);
    word <= 32'h0506_0708;
    @(posedge clk_i);
    #1;
    check(128'({grp_valid_o, pix_ready_o, c0}), 128'({2'b10, 32'h01}));
    do @(posedge clk_i); while (pix_ready_o !== 1'b1);
    pvalid <= 1'b0;
    while (got_cnt != n + 8'h02) @(posedge clk_i);
    check(got_data, {32'h08, 32'h07, 32'h06, 32'h05});
    // Write while a group waits on the slow sink: no ack until it drains
    n = got_cnt;
    pvalid <= 1'b1;
    @(posedge clk_i);
    pvalid <= 1'b0;
    wr(`PUP_REG_OFFSET, 32'h0);
    check(128'(got_cnt), 128'(n + 8'h01));
    stall <= 4'h0;
  endtask : s_stall

  initial begin
    repeat (5000) @(posedge clk_i);
    errors++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    s_regs();
    s_fields();
    s_float();
    s_index();
    s_stall();
    give_verdict();
  end
endmodule : pixel_unpack_transfer_pipe_tb_top

`default_nettype wire

// ==== verification/pup_sink_model.sv ====
// Pixel consumer model: takes groups after a programmable stall.
// Assumes the pipe's valid/ready group port on the single clock.
`timescale 1ns/1ns
`default_nettype none

module pup_sink_model (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              grp_valid_i,
  input  wire pup_pkg::pup_kind_t grp_kind_i,
  input  wire logic [127:0]      grp_data_i,
  input  wire logic [3:0]        stall_i,
  output logic                   grp_ready_o,
  output var pup_pkg::pup_kind_t got_kind_o,
  output logic      [127:0]      got_data_o,
  output logic      [7:0]        got_cnt_o
);
  import pup_pkg::*;
  logic [3:0] wait_q;

  // Ready only after the stall, so the pipe must hold its group
  assign grp_ready_o = grp_valid_i && (wait_q >= stall_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_q     <= 4'h0;
      got_cnt_o  <= 8'h00;
      got_kind_o <= PUP_K_FRGBA;
      got_data_o <= '0;
    end else if (grp_valid_i && grp_ready_o) begin
      wait_q     <= 4'h0;
      got_cnt_o  <= got_cnt_o + 8'h01;
      got_kind_o <= grp_kind_i;
      got_data_o <= grp_data_i;
    end else if (grp_valid_i) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : pup_sink_model

`default_nettype wire
